// ---- inc/watchdog_defs.vh ----
`ifndef WATCHDOG_DEFS_VH
`define WATCHDOG_DEFS_VH

// Register indices; byte address is four times the index
`define WD_IDX_CTL        12'hff0
`define WD_IDX_UPPER      12'hff1
`define WD_IDX_HIGH       12'hff2
`define WD_IDX_LOW        12'hff3
`define WD_IDX_INT_STAT   12'hff4
`define WD_IDX_INT_MASK   12'hff5

// Control register fields
`define WD_CTL_EN_BIT     0
`define WD_CTL_STOP_BIT   5
`define WD_CTL_FLAG_BIT   6

// Interrupt status and mask fields
`define WD_INT_TMO_BIT    0
`define WD_INT_RST_BIT    1
`define WD_INT_SMR_BIT    2

// Reset values
`define WD_RELOAD_RST     8'hff
`define WD_RES_DEFAULT    1'b1
`define WD_MASK_RST       3'h0

// Core reset hold, in oscillator and system clock cycles
`define WD_OSC_HOLD       66
`define WD_SYS_HOLD       16

// Counter width
`define WD_CNT_W          24

`endif

// ---- design/watchdog_timer.v ----
// Function
// - Reset-select time-out in normal/halt requests reset
// - Unprogrammed option bit selects reset response
// - Watchdog reset sets control status flag
// - First enable loads counter from reload
// - Counter decrements once per oscillator cycle
// - Refresh reloads counter, counting then resumes
// - Debug mode keeps counter continuously refreshed
// - Zero reached means time-out; option picks response
// - Interrupt response: request pulse plus status flag
// - Interrupt time-out wraps to all ones
// - Stop-mode reset response gives stop recovery
// - Stop time-out sets status and stop flags
// - Counter keeps running during stop mode
// - Counter 24 bits; reload four or more
// - Three reload bytes after control, reset ones
// - Core reset held 66 osc plus 16 clocks
// - Stop recovery touches control and interrupt status registers
//
// Local design decisions: register access over AHB-Lite and the address map.
`include "watchdog_defs.vh"
`default_nettype none

module watchdog_timer #(
  parameter       CNT_W    = `WD_CNT_W,
  parameter [6:0] OSC_HOLD = `WD_OSC_HOLD,
  parameter [6:0] SYS_HOLD = `WD_SYS_HOLD
) (
  // Clock, reset, enable
  input  wire        ref_clk_i,
  input  wire        rst_n_i,
  input  wire        ce_i,
  // AHB-Lite slave
  input  wire        hsel_i,
  input  wire [31:0] haddr_i,
  input  wire [1:0]  htrans_i,
  input  wire        hwrite_i,
  input  wire [2:0]  hsize_i,
  input  wire [31:0] hwdata_i,
  input  wire        hready_i,
  output wire        hreadyout_o,
  output wire        hresp_o,
  output wire [31:0] hrdata_o,
  // Oscillator pin and option bit
  input  wire        wdt_osc_i,
  input  wire        timeout_reset_select_i,
  // Core status
  input  wire        refresh_i,
  input  wire        debug_mode_i,
  input  wire        stop_mode_i,
  // Responses
  output wire        irq_req_o,
  output wire        sys_reset_req_o,
  output wire        stop_recovery_o,
  output wire        core_reset_o,
  output wire        irq_o
);

  localparam [1:0] H_IDLE = 2'd0;
  localparam [1:0] H_OSC  = 2'd1;
  localparam [1:0] H_SYS  = 2'd2;
  localparam [6:0] OSC_LAST = OSC_HOLD - 7'h01;
  localparam [6:0] SYS_LAST = SYS_HOLD - 7'h01;
  localparam [CNT_W-1:0] CNT_ONE = {{(CNT_W-1){1'b0}}, 1'b1};

  function hit;
    input [11:0] idx;
    input [11:0] ref_idx;
    begin
      hit = (idx == ref_idx);
    end
  endfunction

  reg             osc_s1_reg;
  reg             osc_s2_reg;
  reg             osc_s3_reg;
  reg             opt_reg;
  reg             opt_taken_reg;
  reg             en_reg;
  reg             en_d_reg;
  reg             flag_reg;
  reg             stop_flag_reg;
  reg [7:0]       upper_reg;
  reg [7:0]       high_reg;
  reg [7:0]       low_reg;
  reg [CNT_W-1:0] cnt_reg;
  reg [2:0]       int_stat_reg;
  reg [2:0]       int_mask_reg;
  reg [1:0]       hold_state_reg;
  reg [6:0]       hold_cnt_reg;
  reg             core_reset_reg;
  reg             irq_req_reg;
  reg             sys_reset_req_reg;
  reg             stop_recovery_reg;
  reg             irq_reg;
  reg             wr_pend_reg;
  reg [11:0]      wr_idx_reg;
  reg [31:0]      hrdata_reg;
  reg [31:0]      rd_val;
  reg [2:0]       int_stat_next;

  wire            tick;
  wire            reload_now;
  wire [CNT_W-1:0] reload_val;
  wire            tmo;
  wire            tmo_int;
  wire            tmo_rst;
  wire            tmo_smr;
  wire            addr_ok;
  wire [11:0]     a_idx;
  wire [7:0]      wbyte;

  assign tick       = osc_s2_reg & ~osc_s3_reg;
  assign reload_val = {upper_reg, high_reg, low_reg};
  assign reload_now = (en_reg & ~en_d_reg) | refresh_i | debug_mode_i;
  assign tmo        = en_reg & tick & ~reload_now &
                      (cnt_reg == CNT_ONE);
  assign tmo_int    = tmo & ~opt_reg;
  assign tmo_rst    = tmo & opt_reg & ~stop_mode_i &
                      (hold_state_reg == H_IDLE);
  assign tmo_smr    = tmo & opt_reg & stop_mode_i &
                      (hold_state_reg == H_IDLE);
  assign addr_ok    = hsel_i & htrans_i[1] & hready_i;
  assign a_idx      = haddr_i[13:2];
  assign wbyte      = hwdata_i[7:0];

  // Register read mux
  always @* begin
    rd_val = 32'h0000_0000;
    if (hit(a_idx, `WD_IDX_CTL)) begin
      rd_val[`WD_CTL_FLAG_BIT] = flag_reg;
      rd_val[`WD_CTL_STOP_BIT] = stop_flag_reg;
      rd_val[`WD_CTL_EN_BIT]   = en_reg;
    end else if (hit(a_idx, `WD_IDX_UPPER)) begin
      rd_val[7:0] = upper_reg;
    end else if (hit(a_idx, `WD_IDX_HIGH)) begin
      rd_val[7:0] = high_reg;
    end else if (hit(a_idx, `WD_IDX_LOW)) begin
      rd_val[7:0] = low_reg;
    end else if (hit(a_idx, `WD_IDX_INT_STAT)) begin
      rd_val[2:0] = int_stat_reg;
    end else if (hit(a_idx, `WD_IDX_INT_MASK)) begin
      rd_val[2:0] = int_mask_reg;
    end
  end

  // Interrupt status: write one clears, a new event wins
  always @* begin
    int_stat_next = int_stat_reg;
    if (wr_pend_reg && hit(wr_idx_reg, `WD_IDX_INT_STAT)) begin
      int_stat_next = int_stat_next & ~wbyte[2:0];
    end
    if (tmo_int) begin
      int_stat_next[`WD_INT_TMO_BIT] = 1'b1;
    end
    if (tmo_rst) begin
      int_stat_next[`WD_INT_RST_BIT] = 1'b1;
    end
    if (tmo_smr) begin
      int_stat_next[`WD_INT_SMR_BIT] = 1'b1;
    end
  end

  // Bus slave, oscillator sync, option capture
  always @(posedge ref_clk_i) begin
    if (!rst_n_i) begin
      osc_s1_reg    <= 1'b0;
      osc_s2_reg    <= 1'b0;
      osc_s3_reg    <= 1'b0;
      opt_reg       <= `WD_RES_DEFAULT;
      opt_taken_reg <= 1'b0;
      wr_pend_reg   <= 1'b0;
      wr_idx_reg    <= 12'h000;
      hrdata_reg    <= 32'h0000_0000;
    end else if (ce_i) begin
      osc_s1_reg <= wdt_osc_i;
      osc_s2_reg <= osc_s1_reg;
      osc_s3_reg <= osc_s2_reg;
      if (!opt_taken_reg) begin
        opt_reg       <= timeout_reset_select_i;
        opt_taken_reg <= 1'b1;
      end
      wr_pend_reg <= addr_ok & hwrite_i;
      if (addr_ok) begin
        wr_idx_reg <= a_idx;
      end
      if (addr_ok && !hwrite_i) begin
        hrdata_reg <= rd_val;
      end
    end
  end

  // Software registers and status flags
  always @(posedge ref_clk_i) begin
    if (!rst_n_i) begin
      en_reg        <= 1'b0;
      en_d_reg      <= 1'b0;
      flag_reg      <= 1'b0;
      stop_flag_reg <= 1'b0;
      upper_reg     <= `WD_RELOAD_RST;
      high_reg      <= `WD_RELOAD_RST;
      low_reg       <= `WD_RELOAD_RST;
      int_stat_reg  <= 3'h0;
      int_mask_reg  <= `WD_MASK_RST;
      irq_reg       <= 1'b0;
    end else if (ce_i) begin
      en_d_reg <= en_reg;
      if (wr_pend_reg) begin
        if (hit(wr_idx_reg, `WD_IDX_CTL)) begin
          en_reg <= wbyte[`WD_CTL_EN_BIT];
        end else if (hit(wr_idx_reg, `WD_IDX_UPPER)) begin
          upper_reg <= wbyte;
        end else if (hit(wr_idx_reg, `WD_IDX_HIGH)) begin
          high_reg <= wbyte;
        end else if (hit(wr_idx_reg, `WD_IDX_LOW)) begin
          low_reg <= wbyte;
        end else if (hit(wr_idx_reg, `WD_IDX_INT_MASK)) begin
          int_mask_reg <= wbyte[2:0];
        end
      end
      // Flags clear by writing one; a time-out in the same cycle wins
      if (tmo_int | tmo_rst | tmo_smr) begin
        flag_reg <= 1'b1;
      end else if (wr_pend_reg && hit(wr_idx_reg, `WD_IDX_CTL) &&
                   wbyte[`WD_CTL_FLAG_BIT]) begin
        flag_reg <= 1'b0;
      end
      if (tmo_smr) begin
        stop_flag_reg <= 1'b1;
      end else if (wr_pend_reg && hit(wr_idx_reg, `WD_IDX_CTL) &&
                   wbyte[`WD_CTL_STOP_BIT]) begin
        stop_flag_reg <= 1'b0;
      end
      int_stat_reg <= int_stat_next;
      irq_reg      <= |(int_stat_next & int_mask_reg);
    end
  end

  // Down counter; runs regardless of stop mode
  always @(posedge ref_clk_i) begin
    if (!rst_n_i) begin
      cnt_reg <= {CNT_W{1'b1}};
    end else if (ce_i) begin
      if (en_reg && reload_now) begin
        cnt_reg <= reload_val;
      end else if (en_reg && tick) begin
        if (cnt_reg == {CNT_W{1'b0}} && opt_reg) begin
          cnt_reg <= reload_val;
        end else begin
          cnt_reg <= cnt_reg - CNT_ONE;
        end
      end
    end
  end

  // Response pulses and core reset hold
  always @(posedge ref_clk_i) begin
    if (!rst_n_i) begin
      irq_req_reg       <= 1'b0;
      sys_reset_req_reg <= 1'b0;
      stop_recovery_reg <= 1'b0;
      hold_state_reg    <= H_IDLE;
      hold_cnt_reg      <= 7'h00;
      core_reset_reg    <= 1'b0;
    end else if (ce_i) begin
      irq_req_reg       <= tmo_int;
      sys_reset_req_reg <= tmo_rst;
      stop_recovery_reg <= tmo_smr;
      case (hold_state_reg)
        H_IDLE: begin
          if (tmo_rst | tmo_smr) begin
            hold_state_reg <= H_OSC;
            hold_cnt_reg   <= 7'h00;
            core_reset_reg <= 1'b1;
          end
        end
        H_OSC: begin
          if (tick) begin
            if (hold_cnt_reg == OSC_LAST) begin
              hold_state_reg <= H_SYS;
              hold_cnt_reg   <= 7'h00;
            end else begin
              hold_cnt_reg <= hold_cnt_reg + 7'h01;
            end
          end
        end
        H_SYS: begin
          if (hold_cnt_reg == SYS_LAST) begin
            hold_state_reg <= H_IDLE;
            core_reset_reg <= 1'b0;
          end else begin
            hold_cnt_reg <= hold_cnt_reg + 7'h01;
          end
        end
        default: begin
          hold_state_reg <= H_IDLE;
          core_reset_reg <= 1'b0;
        end
      endcase
    end
  end

  assign hreadyout_o     = 1'b1;
  assign hresp_o         = 1'b0;
  assign hrdata_o        = hrdata_reg;
  assign irq_req_o       = irq_req_reg;
  assign sys_reset_req_o = sys_reset_req_reg;
  assign stop_recovery_o = stop_recovery_reg;
  assign core_reset_o    = core_reset_reg;
  assign irq_o           = irq_reg;

endmodule // watchdog_timer

`default_nettype wire

// ---- bench/watchdog_timer_chk.sv ----
`default_nettype none
module watchdog_timer_chk #(
  parameter OSC_HOLD = 66,
  parameter SYS_HOLD = 16
) (
  // Clock and reset
  input wire logic ref_clk_i,
  input wire logic rst_n_i,
  // Core side inputs
  input wire logic timeout_reset_select_i,
  input wire logic refresh_i,
  input wire logic debug_mode_i,
  input wire logic stop_mode_i,
  // Outputs
  input wire logic hreadyout_o,
  input wire logic hresp_o,
  input wire logic irq_req_o,
  input wire logic sys_reset_req_o,
  input wire logic stop_recovery_o,
  input wire logic core_reset_o
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking @(posedge ref_clk_i); endclocking
  default disable iff (!rst_n_i);
  wire rst_evt;
  assign rst_evt = sys_reset_req_o | stop_recovery_o;
  bus_okay_a: assert property (hreadyout_o && !hresp_o)
    else $error("bus not ready or not okay");
  irq_pulse_a: assert property (irq_req_o |=> !irq_req_o)
    else $error("irq request longer than one cycle");
  irq_select_a: assert property (irq_req_o |-> !timeout_reset_select_i)
    else $error("irq request in reset response");
  rst_select_a: assert property (rst_evt |-> timeout_reset_select_i)
    else $error("reset request in irq response");
  run_reset_a: assert property (
    sys_reset_req_o |-> !$past(stop_mode_i))
    else $error("system reset during stop");
  stop_only_a: assert property (
    stop_recovery_o |-> $past(stop_mode_i))
    else $error("stop recovery outside stop");
  hold_start_a: assert property (rst_evt |-> ##[0:2] core_reset_o)
    else $error("core reset not started");
  hold_len_a: assert property ($rose(core_reset_o) |-> core_reset_o[*8])
    else $error("core reset hold too short");
  hold_nodup_a: assert property ($past(core_reset_o) |-> !rst_evt)
    else $error("reset request during hold");
  debug_quiet_a: assert property (
    debug_mode_i[*8] |=> !(irq_req_o || rst_evt))
    else $error("time-out in debug");
  refresh_quiet_a: assert property (refresh_i[*8] |=> !rst_evt)
    else $error("time-out while refreshed");
endmodule // watchdog_timer_chk
bind watchdog_timer watchdog_timer_chk #(.OSC_HOLD(OSC_HOLD),
  .SYS_HOLD(SYS_HOLD)) chk_u (.ref_clk_i(ref_clk_i), .rst_n_i(rst_n_i),
  .timeout_reset_select_i(timeout_reset_select_i), .refresh_i(refresh_i),
  .debug_mode_i(debug_mode_i), .stop_mode_i(stop_mode_i),
  .hreadyout_o(hreadyout_o), .hresp_o(hresp_o), .irq_req_o(irq_req_o),
  .sys_reset_req_o(sys_reset_req_o), .stop_recovery_o(stop_recovery_o),
  .core_reset_o(core_reset_o));
`default_nettype wire

// ---- bench/wd_far_model.sv ----
`default_nettype none
module wd_far_model (
  // Clock
  input  wire logic clk_i,
  // Requests from the watchdog
  input  wire logic irq_req_i,
  input  wire logic rst_req_i,
  input  wire logic stop_rec_i,
  // Oscillator and request counts
  output var logic  osc_o,
  output var int    irq_cnt_o,
  output var int    rst_cnt_o,
  output var int    stop_cnt_o
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [1:0] div_reg;
  initial begin
    div_reg = 2'h0;
    osc_o = 1'b0;
    irq_cnt_o = 0;
    rst_cnt_o = 0;
    stop_cnt_o = 0;
  end
  // Free-running RC oscillator, one tick per eight clocks
  always @(posedge clk_i) begin
    div_reg <= div_reg + 2'h1;
    if (div_reg == 2'h3)
      osc_o <= ~osc_o;
  end
  // Interrupt and reset controllers count requests
  always @(posedge clk_i) begin
    irq_cnt_o <= irq_cnt_o + int'(irq_req_i);
    rst_cnt_o <= rst_cnt_o + int'(rst_req_i);
    stop_cnt_o <= stop_cnt_o + int'(stop_rec_i);
  end
endmodule // wd_far_model
`default_nettype wire

// ---- bench/watchdog_timer_test.sv ----
`default_nettype none
module watchdog_timer_test;
  timeunit 1ns;
  timeprecision 1ns;
  logic        ref_clk_i = 1'b0;
  logic        rst_n_i = 1'b0;
  logic        ce_i = 1'b1;
  logic [31:0] haddr_i = 32'h0;
  logic [1:0]  htrans_i = 2'h0;
  logic        hwrite_i = 1'b0;
  logic [31:0] hwdata_i = 32'h0;
  logic        res_sel = 1'b1;
  logic        refresh_i = 1'b0;
  logic        debug_mode_i = 1'b0;
  logic        stop_mode_i = 1'b0;
  wire         hreadyout_o, hresp_o, irq_req_o, sys_reset_req_o;
  wire         stop_recovery_o, core_reset_o, irq_o, osc;
  wire  [31:0] hrdata_o;
  int          fails = 0;
  int          checks = 0;
  int          n_irq, n_rst, n_stop;
  logic [31:0] rd;
  // Hold is three model ticks of eight clocks, then two clocks
  localparam int HOLD_EXP = 3 * 8 + 2;
  int          hold_len = 0;
  int          hold_last = 0;
  logic [31:0] row_addr [7] = '{32'h3fc0, 32'h3fc4, 32'h3fc8, 32'h3fcc,
                                32'h3fd0, 32'h3fd4, 32'h3fd8};
  logic [31:0] row_exp [7] = '{32'h0, 32'hff, 32'hff, 32'hff,
                               32'h0, 32'h0, 32'h0};

  always #5 ref_clk_i = ~ref_clk_i;

  // Length of the last core reset hold, in clocks
  always @(posedge ref_clk_i) begin
    if (core_reset_o === 1'b1) begin
      hold_len <= hold_len + 1;
    end else if (hold_len != 0) begin
      hold_last <= hold_len;
      hold_len <= 0;
    end
  end

  watchdog_timer #(.OSC_HOLD(7'd3), .SYS_HOLD(7'd2)) dut_u (
    .ref_clk_i(ref_clk_i), .rst_n_i(rst_n_i), .ce_i(ce_i), .hsel_i(1'b1),
    .haddr_i(haddr_i), .htrans_i(htrans_i), .hwrite_i(hwrite_i),
    .hsize_i(3'h2), .hwdata_i(hwdata_i), .hready_i(hreadyout_o),
    .hreadyout_o(hreadyout_o), .hresp_o(hresp_o), .hrdata_o(hrdata_o),
    .wdt_osc_i(osc), .timeout_reset_select_i(res_sel),
    .refresh_i(refresh_i), .debug_mode_i(debug_mode_i),
    .stop_mode_i(stop_mode_i), .irq_req_o(irq_req_o),
    .sys_reset_req_o(sys_reset_req_o), .stop_recovery_o(stop_recovery_o),
    .core_reset_o(core_reset_o), .irq_o(irq_o));

  wd_far_model far_u (.clk_i(ref_clk_i), .irq_req_i(irq_req_o),
    .rst_req_i(sys_reset_req_o), .stop_rec_i(stop_recovery_o),
    .osc_o(osc), .irq_cnt_o(n_irq), .rst_cnt_o(n_rst), .stop_cnt_o(n_stop));

  task automatic final_report;
    $display("checks=%0d fails=%0d", checks, fails);
    if (fails == 0 && checks > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    checks++;
    if (seen !== exp) begin
      fails++;
      $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  task automatic bus(input logic [31:0] a, input logic w,
                     input logic [31:0] d);
    @(posedge ref_clk_i);
    htrans_i <= 2'h2;
    haddr_i <= a;
    hwrite_i <= w;
    do @(posedge ref_clk_i); while (hreadyout_o !== 1'b1);
    htrans_i <= 2'h0;
    hwdata_i <= d;
    do @(posedge ref_clk_i); while (hreadyout_o !== 1'b1);
    rd = hrdata_o;
  endtask

  task automatic do_reset(input logic sel);
    rst_n_i <= 1'b0;
    res_sel <= sel;
    repeat (5) @(posedge ref_clk_i);
    rst_n_i <= 1'b1;
  endtask

  task automatic arm;
    bus(32'h3fc4, 1'b1, 32'h0);
    bus(32'h3fc8, 1'b1, 32'h0);
    bus(32'h3fcc, 1'b1, 32'h4);
    bus(32'h3fd4, 1'b1, 32'h7);
    bus(32'h3fc0, 1'b1, 32'h1);
  endtask

  task automatic wait_evt(input int total);
    for (int i = 0; i < 600 && n_irq + n_rst + n_stop < total; i++)
      @(posedge ref_clk_i);
    if (n_irq + n_rst + n_stop < total) begin
      fails++;
      final_report();
    end
  endtask

  initial begin
    repeat (20000) @(posedge ref_clk_i);
    fails++;
    final_report();
  end

  initial begin
    do_reset(1'b1);
    for (int i = 0; i < 7; i++) begin
      bus(row_addr[i], 1'b0, 32'h0);
      chk(rd, row_exp[i]);
    end
    arm();
    repeat (16) @(posedge ref_clk_i);
    chk(n_irq + n_rst + n_stop, 32'h0);
    wait_evt(1);
    refresh_i <= 1'b1;
    chk(n_rst, 32'h1);
    bus(32'h3fc0, 1'b0, 32'h0);
    chk(rd, 32'h41);
    bus(32'h3fd0, 1'b0, 32'h0);
    chk(rd, 32'h2);
    chk({31'h0, irq_o}, 32'h1);
    bus(32'h3fd0, 1'b1, 32'h7);
    bus(32'h3fc0, 1'b1, 32'h41);
    bus(32'h3fc0, 1'b0, 32'h0);
    chk(rd, 32'h1);
    chk({31'h0, irq_o}, 32'h0);
    repeat (200) @(posedge ref_clk_i);
    refresh_i <= 1'b0;
    debug_mode_i <= 1'b1;
    repeat (200) @(posedge ref_clk_i);
    chk(n_rst, 32'h1);
    chk(hold_last, HOLD_EXP);
    debug_mode_i <= 1'b0;
    stop_mode_i <= 1'b1;
    wait_evt(2);
    debug_mode_i <= 1'b1;
    chk(n_stop, 32'h1);
    bus(32'h3fc0, 1'b0, 32'h0);
    chk(rd, 32'h61);
    repeat (40) @(posedge ref_clk_i);
    chk(hold_last, HOLD_EXP);
    stop_mode_i <= 1'b0;
    debug_mode_i <= 1'b0;
    do_reset(1'b0);
    arm();
    wait_evt(3);
    chk(n_irq, 32'h1);
    bus(32'h3fc0, 1'b0, 32'h0);
    chk(rd, 32'h41);
    chk({31'h0, core_reset_o}, 32'h0);
    repeat (300) @(posedge ref_clk_i);
    chk(n_irq, 32'h1);
    chk({31'h0, irq_o}, 32'h1);
    ce_i <= 1'b0;
    bus(32'h3fd4, 1'b1, 32'h0);
    ce_i <= 1'b1;
    repeat (2) @(posedge ref_clk_i);
    chk({31'h0, irq_o}, 32'h1);
    bus(32'h3fd4, 1'b1, 32'h0);
    repeat (2) @(posedge ref_clk_i);
    chk({31'h0, irq_o}, 32'h0);
    final_report();
  end
endmodule // watchdog_timer_test
`default_nettype wire
